// ==== dicfg_top.sv ====
// Drive bring-up configuration bytes with their sequencer and pin mirrors.
`timescale 1ns/100ps
`include "dicfg_map.svh"

// What this block does
// - Retry bit one retries packet commands.
// - Init byte bit 7 shows sequencer active.
// - Skip bit: only reset drive, write control.
// - Highest unit number from init bits 2:0.
// - Offset nine bit 7 mirrors enable pin.
// - Alternate mode: disk ready active high.
module dicfg_top #(
  parameter int RST_CYCLES = `DICFG_DRV_RST_CYCLES
) (
  // Clock and reset.
  input  wire logic          clk_sys_in,
  input  wire logic          rst_in,
  // Configuration byte load and read-back.
  input  wire logic          cfg_wr_in,
  input  wire logic          cfg_rd_in,
  input  wire logic [7:0]    cfg_addr_in,
  input  wire logic [7:0]    cfg_wdata_in,
  input  wire logic          cfg_done_in,
  output logic      [7:0]    cfg_rdata_out,
  output logic               cfg_rvalid_out,
  // Pins and neighbouring configuration.
  input  wire logic          ata_enable_pin_level_in,
  input  wire logic          alternate_interface_mode_in,
  input  wire logic          disk_ready_input_in,
  input  wire logic          disk_ready_pol_in,
  input  wire logic          full_init_done_in,
  // Settings and sequencer state for the drive engine.
  output logic               slow_packet_device_retry_out,
  output logic               forced_translation_out,
  output logic               skip_drive_bringup_out,
  output dicfg_pkg::dicfg_lun_t highest_unit_number_out,
  output logic               disk_ready_out,
  output logic               init_active_out,
  output logic               drive_reset_out,
  output logic               devctl_wr_out,
  output logic               full_init_req_out,
  output logic               cmd_enable_out
);
  import dicfg_pkg::*;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  wire        en_pin_s = pin_s2_q[0];
  wire        alternate_interface_mode_s  = pin_s2_q[1];
  wire        rdy_s    = pin_s2_q[2];

  // Two stages before any logic looks at an asynchronous pin.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {disk_ready_input_in, alternate_interface_mode_in, ata_enable_pin_level_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ********************************************************************
  // Configuration bytes
  // ********************************************************************
  logic started_q;
  wire  start   = cfg_done_in & ~started_q;
  // Writes are honoured only before bring-up starts, so the settings stay fixed
  // while the sequencer runs on them.
  // The start edge itself already refuses writes, so the sequencer never sees
  // a field change under it.
  wire  wr_open = cfg_wr_in & ~started_q & ~cfg_done_in;
  wire  wr_ret  = wr_open & (cfg_addr_in == `DICFG_OFS_RETRY);
  wire  wr_ini  = wr_open & (cfg_addr_in == `DICFG_OFS_INIT);

  // Reserved bits are not stored, so they always read back as zero.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      started_q                    <= 1'b0;
      slow_packet_device_retry_out <= `DICFG_RETRY_RST;
      forced_translation_out       <= `DICFG_FORCE_RST;
      skip_drive_bringup_out       <= `DICFG_SKIP_RST;
      highest_unit_number_out      <= `DICFG_LUN_RST;
    end else begin
      started_q <= started_q | cfg_done_in;
      if (wr_ret) begin
        slow_packet_device_retry_out <= cfg_wdata_in[`DICFG_RETRY_BIT];
      end
      if (wr_ini) begin
        forced_translation_out  <= cfg_wdata_in[`DICFG_FORCE_BIT];
        skip_drive_bringup_out  <= cfg_wdata_in[`DICFG_SKIP_BIT];
        highest_unit_number_out <= cfg_wdata_in[`DICFG_LUN_HI:`DICFG_LUN_LO];
      end
    end
  end

  // ********************************************************************
  // Read-back
  // ********************************************************************
  wire [7:0] rd_ret = {7'h00, slow_packet_device_retry_out};
  wire [7:0] rd_ini = {init_active_out, forced_translation_out, skip_drive_bringup_out,
                       2'h0, highest_unit_number_out};
  wire [7:0] rd_pin = {en_pin_s, 7'h00};
  wire [7:0] rd_mux = (cfg_addr_in == `DICFG_OFS_RETRY) ? rd_ret :
                      (cfg_addr_in == `DICFG_OFS_INIT)  ? rd_ini :
                      (cfg_addr_in == `DICFG_OFS_PIN)   ? rd_pin : 8'h00;

  // Read data one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cfg_rdata_out  <= 8'h00;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rdata_out  <= cfg_rd_in ? rd_mux : 8'h00;
      cfg_rvalid_out <= cfg_rd_in;
    end
  end

  // ********************************************************************
  // Disk ready polarity
  // ********************************************************************
  // The polarity setting has no say in alternate interface mode.
  wire rdy_eff = alternate_interface_mode_s ? rdy_s : (rdy_s ^ disk_ready_pol_in);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      disk_ready_out <= 1'b0;
    end else begin
      disk_ready_out <= rdy_eff;
    end
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  dicfg_seq #(
    .RST_CYCLES (RST_CYCLES)
  ) u_seq (
    .clk_sys_in        (clk_sys_in),
    .rst_in            (rst_in),
    .start_in          (start),
    .skip_in           (skip_drive_bringup_out),
    .full_done_in      (full_init_done_in),
    .active_out        (init_active_out),
    .drive_reset_out   (drive_reset_out),
    .devctl_wr_out     (devctl_wr_out),
    .full_init_req_out (full_init_req_out),
    .cmd_enable_out    (cmd_enable_out)
  );

  // ********************************************************************
  // Assertions
  // ********************************************************************
  retry_follows_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_ret |=> slow_packet_device_retry_out == $past(cfg_wdata_in[0]))
    else $error("Retry setting did not follow the write.");

  active_bit_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cfg_rd_in && cfg_addr_in == 8'h08 |=> cfg_rdata_out[7] == $past(init_active_out))
    else $error("Active bit read-back is wrong.");

  skip_path_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(devctl_wr_out) && skip_drive_bringup_out |=> cmd_enable_out && !full_init_req_out)
    else $error("Skipped bring-up did not go straight to commands.");

  full_path_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(devctl_wr_out) && !skip_drive_bringup_out |=> full_init_req_out)
    else $error("Normal bring-up skipped full initialization.");

  unit_number_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_ini |=> highest_unit_number_out == $past(cfg_wdata_in[2:0]))
    else $error("Unit number did not follow the write.");

  pin_mirror_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cfg_rd_in && cfg_addr_in == 8'h09 |=> cfg_rdata_out == {$past(pin_s2_q[0]), 7'h00})
    else $error("Enable pin mirror read-back is wrong.");

  frozen_cfg_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    started_q || cfg_done_in |=> $stable(skip_drive_bringup_out) &&
                                 $stable(highest_unit_number_out))
    else $error("Configuration changed after bring-up start.");

  reset_first_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    start |=> drive_reset_out && init_active_out)
    else $error("Bring-up did not start with drive reset.");

  alternate_interface_mode_ready_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    alternate_interface_mode_s |=> disk_ready_out == $past(rdy_s))
    else $error("Disk ready not active high in alternate mode.");

endmodule // dicfg_top

// ==== dicfg_map.svh ====
// Offsets, field positions, reset values and counts of the drive bring-up configuration bytes.
`ifndef DICFG_MAP_SVH
`define DICFG_MAP_SVH

// ********************************************************************
// Byte offsets in the configuration memory
// ********************************************************************
`define DICFG_OFS_RETRY       8'h07
`define DICFG_OFS_INIT        8'h08
`define DICFG_OFS_PIN         8'h09

// ********************************************************************
// Field positions
// ********************************************************************
`define DICFG_RETRY_BIT       0
`define DICFG_ACTIVE_BIT      7
`define DICFG_FORCE_BIT       6
`define DICFG_SKIP_BIT        5
`define DICFG_LUN_HI          2
`define DICFG_LUN_LO          0
`define DICFG_PIN_BIT         7

// ********************************************************************
// Reset values and counts
// ********************************************************************
`define DICFG_RETRY_RST       1'h0
`define DICFG_FORCE_RST       1'h0
`define DICFG_SKIP_RST        1'h0
`define DICFG_LUN_RST         3'h0
`define DICFG_DRV_RST_CYCLES  16

`endif

// ==== dicfg_pkg.sv ====
// Types shared by the drive bring-up configuration block.
package dicfg_pkg;

  // Bring-up sequencer states.
  typedef enum logic [2:0] {
    DICFG_IDLE,
    DICFG_RESET,
    DICFG_DEVCTL,
    DICFG_FULL,
    DICFG_RUN
  } dicfg_state_t;

  // Logical unit number field.
  typedef logic [2:0] dicfg_lun_t;

endpackage

// ==== dicfg_seq.sv ====
// Drive bring-up sequencer: reset, device control write, optional full initialization.
`timescale 1ns/100ps
`include "dicfg_map.svh"

module dicfg_seq #(
  parameter int RST_CYCLES = `DICFG_DRV_RST_CYCLES
) (
  // Clock and reset.
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Control from the configuration bank, and full initialization done from the drive.
  input  wire logic start_in,
  input  wire logic skip_in,
  input  wire logic full_done_in,
  // Sequencer outputs, all registered.
  output logic      active_out,
  output logic      drive_reset_out,
  output logic      devctl_wr_out,
  output logic      full_init_req_out,
  output logic      cmd_enable_out
);
  import dicfg_pkg::*;

  // ********************************************************************
  // Parameter check
  // ********************************************************************
  if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin : g_bad_rst
    $error("RST_CYCLES must lie in 1..65535");
  end

  dicfg_state_t state_q, state_d;
  logic [15:0]  cnt_q, cnt_d;
  wire          cnt_done = (cnt_q == 16'(RST_CYCLES - 1));

  // Next state; a skipped bring-up goes straight to command processing after
  // the device control write.
  always_comb begin
    state_d = state_q;
    cnt_d   = 16'h0000;
    case (state_q)
      DICFG_IDLE: begin
        if (start_in) begin
          state_d = DICFG_RESET;
        end
      end
      DICFG_RESET: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_done) begin
          state_d = DICFG_DEVCTL;
        end
      end
      DICFG_DEVCTL: begin
        state_d = skip_in ? DICFG_RUN : DICFG_FULL;
      end
      DICFG_FULL: begin
        if (full_done_in) begin
          state_d = DICFG_RUN;
        end
      end
      DICFG_RUN: begin
        state_d = DICFG_RUN;
      end
      default: begin
        state_d = DICFG_IDLE;
      end
    endcase
  end

  // State and registered outputs, decoded from the next state so they line up.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q           <= DICFG_IDLE;
      cnt_q             <= 16'h0000;
      active_out        <= 1'b0;
      drive_reset_out   <= 1'b0;
      devctl_wr_out     <= 1'b0;
      full_init_req_out <= 1'b0;
      cmd_enable_out    <= 1'b0;
    end else begin
      state_q           <= state_d;
      cnt_q             <= cnt_d;
      active_out        <= (state_d != DICFG_IDLE) && (state_d != DICFG_RUN);
      drive_reset_out   <= (state_d == DICFG_RESET);
      devctl_wr_out     <= (state_d == DICFG_DEVCTL);
      full_init_req_out <= (state_d == DICFG_FULL);
      cmd_enable_out    <= (state_d == DICFG_RUN);
    end
  end

endmodule // dicfg_seq

// ==== dicfg_drive_model.sv ====
// Behavioural drive model on the far side of the bring-up sequencer.
`timescale 1ns/100ps

module dicfg_drive_model #(
  parameter int INIT_DELAY = 5
) (
  // Clock, requests from the bridge and the ready level from the bench.
  input  wire logic clk_sys_in,
  input  wire logic full_init_req_in,
  input  wire logic ready_level_in,
  // Answers to the bridge.
  output logic      full_init_done_out,
  output logic      disk_ready_pin_out
);
  int unsigned wait_cnt = 0;

  initial full_init_done_out = 1'b0;

  // A slow drive: full initialization ends a fixed time after it is asked for.
  // The answer moves on the edge itself, like any same-clock neighbour would.
  always @(posedge clk_sys_in) begin
    full_init_done_out <= full_init_req_in && (wait_cnt == INIT_DELAY);
    wait_cnt           <= full_init_req_in ? wait_cnt + 1 : 0;
  end

  // The ready pin follows the level the bench asks the drive to show.
  assign disk_ready_pin_out = ready_level_in;
endmodule // dicfg_drive_model

// ==== dicfg_top_tb_top.sv ====
// Self-checking bench for the drive bring-up configuration bytes.
`timescale 1ns/100ps
`include "dicfg_map.svh"

module dicfg_top_tb_top;
  import dicfg_pkg::*;
  localparam int RST = 2;
  // ********************************************************************
  // Signals
  // ********************************************************************
  logic       clk_sys_in = 0, rst_in = 1, wr = 0, rd = 0, done = 0;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic       pin = 0, alt = 0, rdy = 0, pol = 0, fdone, rvalid, retry, frc, skip;
  logic       drdy, active, drst, devctl, freq, cmden, rdy_pin;
  dicfg_lun_t lun;
  int         miscompares = 0, check_count = 0;

  dicfg_top #(.RST_CYCLES(RST)) DUT (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cfg_wr_in(wr), .cfg_rd_in(rd),
    .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_done_in(done),
    .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .ata_enable_pin_level_in(pin),
    .alternate_interface_mode_in(alt), .disk_ready_input_in(rdy_pin),
    .disk_ready_pol_in(pol), .full_init_done_in(fdone),
    .slow_packet_device_retry_out(retry), .forced_translation_out(frc),
    .skip_drive_bringup_out(skip), .highest_unit_number_out(lun),
    .disk_ready_out(drdy), .init_active_out(active), .drive_reset_out(drst),
    .devctl_wr_out(devctl), .full_init_req_out(freq), .cmd_enable_out(cmden));

  dicfg_drive_model #(.INIT_DELAY(5)) partner (
    .clk_sys_in(clk_sys_in), .full_init_req_in(freq), .ready_level_in(rdy),
    .full_init_done_out(fdone), .disk_ready_pin_out(rdy_pin));

  // Free-running 250 MHz system clock.
  initial forever #2 clk_sys_in = ~clk_sys_in;

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Inputs move 1 ns after the edge so the design never races the bench.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // Strobes are left up so back-to-back transfers never toggle them twice.
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr = w;
    rd = r;
    addr = a;
    wdata = d;
    tick(1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    chk(rvalid, 1'b1);
    chk(rdata, exp);
  endtask

  task automatic do_reset();
    rst_in = 1;
    done = 0;
    tick(3);
    rst_in = 0;
  endtask

  // Runs one bring-up with the init byte read back every cycle meanwhile.
  task automatic bringup(input logic skp);
    int   nrst, ndev, nreq;
    logic prev, got;
    nrst = 0;
    ndev = 0;
    nreq = 0;
    prev = 0;
    got = 0;
    done = 1;
    bus(1'b0, 1'b1, `DICFG_OFS_INIT, 8'h00);
    // Outputs are counted before each edge, so the cycle launched by the start
    // edge is counted as well.
    for (int i = 0; i < 200 && cmden !== 1'b1; i++) begin
      if (drst | devctl | freq) chk(active, 1'b1);
      prev = active;
      got |= fdone;
      nrst += drst;
      ndev += devctl;
      nreq += freq;
      tick(1);
      chk(rdata[7], prev);
      chk(rdata[5], skp);
      if (cmden === 1'b1 && !skp) chk(got, 1'b1);
    end
    chk(8'(nrst), 8'(RST));
    chk(8'(ndev), 8'h01);
    chk(nreq == 0, skp);
    chk(cmden, 1'b1);
    chk(active, 1'b0);
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    logic [7:0] v, u;
    void'($urandom(8));
    do_reset();
    rdchk(`DICFG_OFS_RETRY, 8'h00);
    rdchk(`DICFG_OFS_INIT, 8'h00);
    rdchk(8'h3C, 8'h00);
    v = 8'h00;
    // Random settings; reserved bits are kept at zero as programmers must.
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom) & 8'h01;
      u = 8'($urandom) & 8'h67;
      if (u[6]) u[5] = 1'b1;
      bus(1'b1, 1'b0, `DICFG_OFS_RETRY, v);
      bus(1'b1, 1'b0, `DICFG_OFS_INIT, u);
      bus(1'b1, 1'b0, 8'h20, 8'hFF);
      chk(retry, v[0]);
      chk({frc, skip}, u[6:5]);
      chk(lun, u[2:0]);
      rdchk(`DICFG_OFS_INIT, u);
      rdchk(`DICFG_OFS_RETRY, v);
    end
    // Skip is cleared before alternate interface mode is ever selected.
    bus(1'b1, 1'b0, `DICFG_OFS_INIT, 8'h07 & u);
    // Every mode and polarity, with a random enable pin level.
    for (int i = 0; i < 8; i++) begin
      {alt, pol, rdy} = 3'(i);
      pin = 1'($urandom);
      tick(5);
      chk(drdy, alt ? rdy : rdy ^ pol);
      rdchk(`DICFG_OFS_PIN, {pin, 7'h00});
    end
    alt = 0;
    bus(1'b1, 1'b0, `DICFG_OFS_INIT, 8'h27);
    bringup(1'b1);
    // The bench stands in for the host driver, which owns drive set-up and the
    // identify command over the ATA path; the bridge must not ask for it.
    chk(freq, 1'b0);
    bus(1'b1, 1'b0, `DICFG_OFS_RETRY, {7'h00, ~v[0]});
    tick(1);
    chk(retry, v[0]);
    rdchk(`DICFG_OFS_INIT, 8'h27);
    do_reset();
    chk(cmden, 1'b0);
    bus(1'b1, 1'b0, `DICFG_OFS_INIT, 8'h03);
    bringup(1'b0);
    give_verdict();
  end
endmodule // dicfg_top_tb_top
